// ---- verilog/pesd_pkg.sv ----
// Package of event codes, masks and timing for the event-select decode block
package pesd_pkg;

  // ****************************************************************
  // Event numbers and unit masks
  // ****************************************************************
  localparam logic [7:0] EVN_XLAT_MISS = 8'h08;
  localparam logic [7:0] UMK_STORE_MISS = 8'h08;
  localparam logic [7:0] EVN_DISAMBIG = 8'h09;
  localparam logic [7:0] UMK_DIS_RESET = 8'h01;
  localparam logic [7:0] UMK_DIS_SUCCESS = 8'h02;
  localparam logic [7:0] EVN_PAGE_WALK = 8'h0C;
  localparam logic [7:0] UMK_WALK_COUNT = 8'h01;
  localparam logic [7:0] UMK_WALK_CYCLES = 8'h02;
  localparam logic [7:0] EVN_FP_UOP = 8'h10;
  localparam logic [7:0] EVN_FP_HELP = 8'h11;
  localparam logic [7:0] EVN_MULTIPLY = 8'h12;
  localparam logic [7:0] UMK_NONE = 8'h00;

  // ****************************************************************
  // Timing and reset values
  // ****************************************************************
  localparam int unsigned DIS_PENALTY_CYCLES = 20;
  localparam logic [4:0] DIS_PENALTY_LAST = 5'(DIS_PENALTY_CYCLES - 1);
  localparam logic [4:0] DIS_CNT_RESET = 5'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    PESD_SEL_NONE,
    PESD_SEL_STORE_MISS,
    PESD_SEL_DIS_RESET,
    PESD_SEL_DIS_SUCCESS,
    PESD_SEL_WALK_COUNT,
    PESD_SEL_WALK_CYCLES,
    PESD_SEL_FP_UOP,
    PESD_SEL_FP_HELP,
    PESD_SEL_MULTIPLY
  } pesd_sel_t;

  typedef struct packed {
    logic store_translation_miss_event;
    logic disambig_reset_cycle;
    logic disambig_success_event;
    logic walk_start;
    logic walk_cycle;
    logic float_compute_uop_event;
    logic float_microcode_help_event;
    logic multiply_exec_event;
  } pesd_events_t;

  typedef enum logic [1:0] {
    PESD_DIS_IDLE,
    PESD_DIS_RECOVER
  } pesd_dis_state_t;

  typedef enum logic [0:0] {
    PESD_WALK_IDLE,
    PESD_WALK_BUSY
  } pesd_walk_state_t;

endpackage : pesd_pkg

// ---- verilog/pesd_evt_if.sv ----
// Interface carrying qualified per-cycle events from the core to the counters
`timescale 1ns/1ps
interface pesd_evt_if;
  import pesd_pkg::*;
  pesd_events_t events;
  modport src (output events);
  modport cnt (input events);
endinterface : pesd_evt_if

// ---- verilog/pesd_counter.sv ----
// One general counter with event and unit-mask selection
`timescale 1ns/1ps
module pesd_counter
  import pesd_pkg::*;
#(
  parameter int CNT_W = 40,
  parameter int CTR_INDEX = 0
) (
  input wire logic sys_clk_i, // Core clock
  input wire logic reset_i, // Async reset, active high
  pesd_evt_if.cnt evt, // Qualified events
  input wire logic [7:0] event_num_i, // Programmed event number
  input wire logic [7:0] unit_mask_i, // Programmed unit mask
  output logic [CNT_W-1:0] count_o // Counter value
);

  // ****************************************************************
  // Selection decode
  // ****************************************************************
  function automatic pesd_sel_t decode_sel(input logic [7:0] num, input logic [7:0] umk,
                                           input int idx);
    pesd_sel_t sel;
    sel = PESD_SEL_NONE;
    if (num == EVN_XLAT_MISS && umk == UMK_STORE_MISS) sel = PESD_SEL_STORE_MISS;
    else if (num == EVN_DISAMBIG && umk == UMK_DIS_RESET) sel = PESD_SEL_DIS_RESET;
    else if (num == EVN_DISAMBIG && umk == UMK_DIS_SUCCESS) sel = PESD_SEL_DIS_SUCCESS;
    else if (num == EVN_PAGE_WALK && umk == UMK_WALK_COUNT) sel = PESD_SEL_WALK_COUNT;
    else if (num == EVN_PAGE_WALK && umk == UMK_WALK_CYCLES) sel = PESD_SEL_WALK_CYCLES;
    else if (num == EVN_FP_UOP && umk == UMK_NONE && idx == 0) sel = PESD_SEL_FP_UOP;
    else if (num == EVN_FP_HELP && umk == UMK_NONE && idx == 1) sel = PESD_SEL_FP_HELP;
    else if (num == EVN_MULTIPLY && umk == UMK_NONE && idx == 1) sel = PESD_SEL_MULTIPLY;
    return sel;
  endfunction : decode_sel

  pesd_sel_t sel;
  logic hit;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    sel = decode_sel(event_num_i, unit_mask_i, CTR_INDEX);
    case (sel)
      PESD_SEL_STORE_MISS: hit = evt.events.store_translation_miss_event;
      PESD_SEL_DIS_RESET: hit = evt.events.disambig_reset_cycle;
      PESD_SEL_DIS_SUCCESS: hit = evt.events.disambig_success_event;
      PESD_SEL_WALK_COUNT: hit = evt.events.walk_start;
      PESD_SEL_WALK_CYCLES: hit = evt.events.walk_cycle;
      PESD_SEL_FP_UOP: hit = evt.events.float_compute_uop_event;
      PESD_SEL_FP_HELP: hit = evt.events.float_microcode_help_event;
      PESD_SEL_MULTIPLY: hit = evt.events.multiply_exec_event;
      default: hit = 1'b0;
    endcase
    // Wraps silently; overflow signalling belongs to the counter owner
    next_count = hit ? count + CNT_W'(1) : count;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign count_o = count;

  AST_CNT_STEP: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ##1 count == $past(count) + CNT_W'($past(hit)))
    else $error("counter did not step by exactly the qualified event");

  AST_CNT_PIN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (event_num_i == EVN_FP_UOP && CTR_INDEX != 0) |-> !hit)
    else $error("compute micro-op event counted on a counter other than zero");

  AST_CNT_PIN1: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ((event_num_i == EVN_MULTIPLY || event_num_i == EVN_FP_HELP) && CTR_INDEX != 1) |-> !hit)
    else $error("counter-one event counted on another counter");

endmodule : pesd_counter

// ---- verilog/pesd_top.sv ----
// Event qualification and two general counters for core performance monitoring
// Behaviour
// - Event 08H with mask 08H counts each store translation miss.
// - Store misses from speculative accesses are counted even if later discarded.
// - Store misses are taken from the second-level data translation buffer only.
// - Event 09H mask 01H counts every cycle a disambiguation misprediction is handled.
// - Misprediction flushes the pipeline and restarts the load after about twenty cycles.
// - Event 09H mask 02H counts loads passing unknown-address stores unblocked.
// - Event 0CH mask 01H counts each page walk started by data or instruction miss.
// - Event 0CH mask 02H counts every cycle a page walk is in progress.
// - Event 10H mask 00H counts computational float micro-ops, counter zero only.
// - Event 11H counts float operations needing microcode assist, counter one only.
// - Vector op with denormal input and denormals-as-zero cleared needs an assist.
// - Vector op with underflow result and flush-to-zero cleared needs an assist.
// - Stack op with NaN or denormal operand, divide by zero or underflow assists.
// - Event 12H counts integer and float multiplies, counter one only.
`timescale 1ns/1ps
module pesd_top
  import pesd_pkg::*;
#(
  parameter int CNT_W = 40
) (
  input wire logic sys_clk_i, // Core clock, 200 MHz
  input wire logic reset_i, // Async reset, active high
  input wire logic [7:0] ctr0_event_num_i, // Counter zero event number
  input wire logic [7:0] ctr0_unit_mask_i, // Counter zero unit mask
  input wire logic [7:0] ctr1_event_num_i, // Counter one event number
  input wire logic [7:0] ctr1_unit_mask_i, // Counter one unit mask
  input wire logic store_lookup_i, // Store translated in second-level buffer
  input wire logic xlat2_miss_i, // Second-level buffer lookup missed
  input wire logic disambig_mispredict_i, // Load collided with older store
  input wire logic unknown_store_load_i, // Load issued behind unknown-address store
  input wire logic load_blocked_i, // That load was blocked
  input wire logic data_walk_req_i, // Data translation miss needs a walk
  input wire logic inst_walk_req_i, // Instruction translation miss needs a walk
  input wire logic walk_done_i, // Page walk finishing this cycle
  input wire logic fp_compute_uop_i, // Computational float micro-op executed
  input wire logic vec_fp_exec_i, // Vector float instruction executed
  input wire logic vec_denormal_in_i, // It saw a denormal input
  input wire logic vec_underflow_i, // It produced an underflow
  input wire logic denormals_as_zero_control_i, // Denormal inputs read as zero
  input wire logic flush_to_zero_control_i, // Underflow results flushed to zero
  input wire logic stack_fp_exec_i, // Stack float instruction executed
  input wire logic stack_nan_denorm_i, // NaN or denormal loaded or read
  input wire logic stack_div_zero_i, // Division by zero
  input wire logic stack_underflow_i, // Underflow output
  input wire logic int_mult_exec_i, // Integer multiply executed
  input wire logic fp_mult_exec_i, // Float multiply executed
  output logic pipeline_flush_o, // Flush pulse on misprediction
  output logic load_restart_o, // Restart pulse for the mispredicted load
  output logic disambig_recovering_o, // Misprediction being handled
  output logic walk_busy_o, // Page walk in progress
  output logic [CNT_W-1:0] general_counter_zero_o, // Counter zero value
  output logic [CNT_W-1:0] general_counter_one_o // Counter one value
);

  pesd_evt_if evt ();

  // ****************************************************************
  // Disambiguation recovery
  // ****************************************************************
  pesd_dis_state_t dis_state;
  pesd_dis_state_t next_dis_state;
  logic [4:0] dis_cnt;
  logic [4:0] next_dis_cnt;
  logic flush;
  logic next_flush;
  logic restart;
  logic next_restart;

  always_comb begin
    next_dis_state = dis_state;
    next_dis_cnt = dis_cnt;
    next_flush = 1'b0;
    next_restart = 1'b0;
    case (dis_state)
      PESD_DIS_IDLE: begin
        if (disambig_mispredict_i) begin
          next_dis_state = PESD_DIS_RECOVER;
          next_dis_cnt = DIS_CNT_RESET;
          next_flush = 1'b1;
        end
      end
      PESD_DIS_RECOVER: begin
        // A fresh collision restarts the penalty instead of stacking a second one
        if (disambig_mispredict_i) begin
          next_dis_cnt = DIS_CNT_RESET;
          next_flush = 1'b1;
        end else if (dis_cnt == DIS_PENALTY_LAST) begin
          next_dis_state = PESD_DIS_IDLE;
          next_restart = 1'b1;
        end else begin
          next_dis_cnt = dis_cnt + 5'h01;
        end
      end
      default: begin
        next_dis_state = PESD_DIS_IDLE;
        next_dis_cnt = DIS_CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dis_state <= PESD_DIS_IDLE;
      dis_cnt <= DIS_CNT_RESET;
      flush <= 1'b0;
      restart <= 1'b0;
    end else begin
      dis_state <= next_dis_state;
      dis_cnt <= next_dis_cnt;
      flush <= next_flush;
      restart <= next_restart;
    end
  end

  // ****************************************************************
  // Page walker occupancy
  // ****************************************************************
  pesd_walk_state_t walk_state;
  pesd_walk_state_t next_walk_state;
  logic walk_start;

  always_comb begin
    next_walk_state = walk_state;
    walk_start = 1'b0;
    case (walk_state)
      PESD_WALK_IDLE: begin
        // One walker: simultaneous data and instruction requests start one walk
        if (data_walk_req_i || inst_walk_req_i) begin
          walk_start = 1'b1;
          next_walk_state = PESD_WALK_BUSY;
        end
      end
      PESD_WALK_BUSY: begin
        if (walk_done_i) begin
          next_walk_state = PESD_WALK_IDLE;
        end
      end
      default: next_walk_state = PESD_WALK_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      walk_state <= PESD_WALK_IDLE;
    end else begin
      walk_state <= next_walk_state;
    end
  end

  // ****************************************************************
  // Event qualification
  // ****************************************************************
  logic vec_assist;
  logic stack_assist;

  always_comb begin
    vec_assist = vec_fp_exec_i &&
                 ((vec_denormal_in_i && !denormals_as_zero_control_i) ||
                  (vec_underflow_i && !flush_to_zero_control_i));
    stack_assist = stack_fp_exec_i &&
                   (stack_nan_denorm_i || stack_div_zero_i || stack_underflow_i);
    // No speculation qualifier: discarded stores still count
    evt.events.store_translation_miss_event = store_lookup_i && xlat2_miss_i;
    evt.events.disambig_reset_cycle = (dis_state == PESD_DIS_RECOVER);
    evt.events.disambig_success_event = unknown_store_load_i && !load_blocked_i;
    evt.events.walk_start = walk_start;
    evt.events.walk_cycle = (walk_state == PESD_WALK_BUSY);
    evt.events.float_compute_uop_event = fp_compute_uop_i;
    evt.events.float_microcode_help_event = vec_assist || stack_assist;
    evt.events.multiply_exec_event = int_mult_exec_i || fp_mult_exec_i;
  end

  // ****************************************************************
  // Counters
  // ****************************************************************
  pesd_counter #(.CNT_W(CNT_W), .CTR_INDEX(0)) u_ctr0 (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .evt(evt.cnt),
    .event_num_i(ctr0_event_num_i),
    .unit_mask_i(ctr0_unit_mask_i),
    .count_o(general_counter_zero_o)
  );

  pesd_counter #(.CNT_W(CNT_W), .CTR_INDEX(1)) u_ctr1 (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .evt(evt.cnt),
    .event_num_i(ctr1_event_num_i),
    .unit_mask_i(ctr1_unit_mask_i),
    .count_o(general_counter_one_o)
  );

  assign pipeline_flush_o = flush;
  assign load_restart_o = restart;
  assign disambig_recovering_o = (dis_state == PESD_DIS_RECOVER);
  assign walk_busy_o = (walk_state == PESD_WALK_BUSY);

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_mispredict_alone;
    disambig_mispredict_i && dis_state == PESD_DIS_IDLE;
  endsequence

  sequence s_quiet_recovery;
    (disambig_recovering_o && !disambig_mispredict_i)[*8] ##1
    (disambig_recovering_o && !disambig_mispredict_i)[*8] ##1
    (disambig_recovering_o && !disambig_mispredict_i)[*3];
  endsequence

  AST_FLUSH_ON_MISS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_mispredict_alone |=> pipeline_flush_o && disambig_recovering_o)
    else $error("misprediction did not flush the pipeline");

  AST_PENALTY_LEN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (s_mispredict_alone ##1 s_quiet_recovery) |=>
    disambig_recovering_o && !disambig_mispredict_i |=> load_restart_o && !disambig_recovering_o)
    else $error("recovery did not last exactly the penalty");

  AST_RESTART_AFTER: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    load_restart_o |-> $past(disambig_recovering_o) && !disambig_recovering_o)
    else $error("restart pulse outside the end of recovery");

  AST_WALK_START: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!walk_busy_o && (data_walk_req_i || inst_walk_req_i)) |=> walk_busy_o)
    else $error("walk request did not start a walk");

  AST_WALK_END: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (walk_busy_o && walk_done_i) |=> !walk_busy_o)
    else $error("walk stayed busy after completion");

  AST_ASSIST_DENORM: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (vec_fp_exec_i && vec_denormal_in_i && !denormals_as_zero_control_i)
    |-> evt.events.float_microcode_help_event)
    else $error("denormal vector input without zeroing missed an assist");

  AST_ASSIST_FLUSH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (vec_fp_exec_i && !stack_fp_exec_i && !vec_denormal_in_i && vec_underflow_i &&
     flush_to_zero_control_i) |-> !evt.events.float_microcode_help_event)
    else $error("flushed underflow counted as an assist");

  AST_STORE_MISS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ctr0_event_num_i == EVN_XLAT_MISS && ctr0_unit_mask_i == UMK_STORE_MISS &&
     store_lookup_i && xlat2_miss_i) |=>
    general_counter_zero_o == $past(general_counter_zero_o) + CNT_W'(1))
    else $error("store translation miss not counted");

  AST_MULT_CNT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (ctr1_event_num_i == EVN_MULTIPLY && ctr1_unit_mask_i == UMK_NONE &&
     (int_mult_exec_i || fp_mult_exec_i)) |=>
    general_counter_one_o == $past(general_counter_one_o) + CNT_W'(1))
    else $error("multiply not counted");

endmodule : pesd_top

// ---- verification/tb_top.sv ----
// Self-checking bench for the performance event-select decode block
`timescale 1ns/1ps
module tb_top;
  import pesd_pkg::*;

  // ****************************************************************
  // Signals and design instance
  // ****************************************************************
  localparam int CW = 40;
  localparam logic [9:0] AC [0:9] = '{10'h380, 10'h1A0, 10'h340, 10'h150, 10'h080,
                                       10'h20C, 10'h20A, 10'h209, 10'h38C, 10'h008};
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] ev0, mk0, ev1, mk1;
  logic st_look, x2_miss, mispred, unk_ld, ld_blk, dwalk, iwalk, wdone, fpu;
  logic vexe, vden, vuf, dz_ctl, fz_ctl, sexe, snan, sdiv, suf, imul, fmul;
  logic flush, restart, recov, busy;
  logic [CW-1:0] c0, c1, b0, b1;
  int err_count = 0;
  int n_compared = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  pesd_top #(.CNT_W(CW)) u_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .ctr0_event_num_i(ev0), .ctr0_unit_mask_i(mk0),
    .ctr1_event_num_i(ev1), .ctr1_unit_mask_i(mk1),
    .store_lookup_i(st_look), .xlat2_miss_i(x2_miss),
    .disambig_mispredict_i(mispred), .unknown_store_load_i(unk_ld),
    .load_blocked_i(ld_blk), .data_walk_req_i(dwalk), .inst_walk_req_i(iwalk),
    .walk_done_i(wdone), .fp_compute_uop_i(fpu), .vec_fp_exec_i(vexe),
    .vec_denormal_in_i(vden), .vec_underflow_i(vuf),
    .denormals_as_zero_control_i(dz_ctl), .flush_to_zero_control_i(fz_ctl),
    .stack_fp_exec_i(sexe), .stack_nan_denorm_i(snan), .stack_div_zero_i(sdiv),
    .stack_underflow_i(suf), .int_mult_exec_i(imul), .fp_mult_exec_i(fmul),
    .pipeline_flush_o(flush), .load_restart_o(restart),
    .disambig_recovering_o(recov), .walk_busy_o(busy),
    .general_counter_zero_o(c0), .general_counter_one_o(c1)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [CW-1:0] seen,
                       input logic [CW-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick

  task automatic clear_events();
    {st_look, x2_miss, mispred, unk_ld, ld_blk, dwalk, iwalk, wdone, fpu} = '0;
    {vexe, vden, vuf, dz_ctl, fz_ctl, sexe, snan, sdiv, suf, imul, fmul} = '0;
  endtask : clear_events

  // Selection changes one cycle before the snapshot so no stale pair counts
  task automatic sel(input logic [7:0] a, b, c, d);
    ev0 = a; mk0 = b; ev1 = c; mk1 = d;
    tick(1);
    b0 = c0; b1 = c1;
  endtask : sel

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_store_miss();
    sel(EVN_XLAT_MISS, UMK_STORE_MISS, EVN_XLAT_MISS, UMK_NONE);
    st_look = 1'b1; x2_miss = 1'b1;
    tick(3);
    x2_miss = 1'b0;
    tick(1);
    st_look = 1'b0; x2_miss = 1'b1;
    tick(1);
    clear_events();
    tick(1);
    check("store_miss_ctr0", c0 - b0, 40'h3);
    check("store_miss_ctr1", c1 - b1, 40'h0);
  endtask : t_store_miss

  task automatic t_disambig();
    sel(EVN_DISAMBIG, UMK_DIS_RESET, EVN_DISAMBIG, UMK_DIS_SUCCESS);
    mispred = 1'b1; unk_ld = 1'b1;
    tick(1);
    mispred = 1'b0; ld_blk = 1'b1;
    check("flush", CW'(flush), 40'h1);
    check("recov", CW'(recov), 40'h1);
    tick(1);
    clear_events();
    for (int i = 2; i <= 20; i++) begin
      check("recov", CW'(recov), 40'h1);
      check("flush", CW'(flush), 40'h0);
      tick(1);
    end
    check("recov", CW'(recov), 40'h0);
    check("restart", CW'(restart), 40'h1);
    tick(1);
    check("restart", CW'(restart), 40'h0);
    check("reset_cycles", c0 - b0, 40'h14);
    check("success", c1 - b1, 40'h1);
  endtask : t_disambig

  task automatic t_walk();
    sel(EVN_PAGE_WALK, UMK_WALK_COUNT, EVN_PAGE_WALK, UMK_WALK_CYCLES);
    dwalk = 1'b1;
    tick(1);
    dwalk = 1'b0; iwalk = 1'b1;
    check("busy", CW'(busy), 40'h1);
    tick(1);
    iwalk = 1'b0;
    tick(1);
    wdone = 1'b1;
    tick(1);
    wdone = 1'b0;
    check("busy", CW'(busy), 40'h0);
    // Back-to-back walk, both requests together make one walk
    dwalk = 1'b1; iwalk = 1'b1;
    tick(1);
    dwalk = 1'b0; iwalk = 1'b0; wdone = 1'b1;
    tick(1);
    wdone = 1'b0;
    tick(1);
    check("walk_count", c0 - b0, 40'h2);
    check("walk_cycles", c1 - b1, 40'h4);
  endtask : t_walk

  task automatic t_float();
    sel(EVN_FP_UOP, UMK_NONE, EVN_FP_UOP, UMK_NONE);
    fpu = 1'b1;
    tick(4);
    clear_events();
    tick(1);
    check("fp_uop_ctr0", c0 - b0, 40'h4);
    check("fp_uop_ctr1", c1 - b1, 40'h0);
    sel(EVN_FP_HELP, UMK_NONE, EVN_FP_HELP, UMK_NONE);
    for (int i = 0; i < 10; i++) begin
      b1 = c1;
      {vexe, vden, vuf, dz_ctl, fz_ctl, sexe, snan, sdiv, suf} = AC[i][8:0];
      tick(1);
      clear_events();
      tick(1);
      check("assist_ctr1", c1 - b1, CW'(AC[i][9]));
    end
    check("assist_ctr0", c0 - b0, 40'h0);
  endtask : t_float

  task automatic t_multiply();
    sel(EVN_MULTIPLY, UMK_NONE, EVN_MULTIPLY, UMK_NONE);
    imul = 1'b1;
    tick(1);
    imul = 1'b0; fmul = 1'b1;
    tick(1);
    imul = 1'b1;
    tick(1);
    clear_events();
    tick(1);
    check("mult_ctr1", c1 - b1, 40'h3);
    check("mult_ctr0", c0 - b0, 40'h0);
    sel(EVN_MULTIPLY, UMK_NONE, EVN_MULTIPLY, 8'h01);
    imul = 1'b1;
    tick(1);
    clear_events();
    tick(1);
    check("mult_bad_mask", c1 - b1, 40'h0);
  endtask : t_multiply

  // A second misprediction mid-recovery restarts the full penalty
  task automatic t_dis_retrigger();
    sel(EVN_DISAMBIG, UMK_DIS_RESET, EVN_DISAMBIG, UMK_DIS_SUCCESS);
    mispred = 1'b1;
    tick(1);
    mispred = 1'b0;
    tick(4);
    mispred = 1'b1;
    tick(1);
    mispred = 1'b0;
    check("reflush", CW'(flush), 40'h1);
    tick(19);
    check("recov_long", CW'(recov), 40'h1);
    tick(1);
    check("recov_end", CW'(recov), 40'h0);
    check("restart_late", CW'(restart), 40'h1);
    check("retrig_cycles", c0 - b0, 40'h19);
  endtask : t_dis_retrigger

  // Reset lands in mid-walk to prove it clears state asynchronously
  task automatic t_mid_reset();
    dwalk = 1'b1;
    tick(1);
    dwalk = 1'b0;
    check("busy_pre", CW'(busy), 40'h1);
    #1 reset_i = 1'b1;
    #1;
    check("busy_rst", CW'(busy), 40'h0);
    check("ctr0_rst", c0, 40'h0);
    check("ctr1_rst", c1, 40'h0);
    tick(1);
    reset_i = 1'b0;
    sel(EVN_MULTIPLY, UMK_NONE, EVN_MULTIPLY, UMK_NONE);
    fmul = 1'b1;
    tick(1);
    clear_events();
    tick(1);
    check("ctr1_after_rst", c1, 40'h1);
  endtask : t_mid_reset

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    ev0 = 8'h00; mk0 = 8'h00; ev1 = 8'h00; mk1 = 8'h00;
    clear_events();
    tick(6);
    check("ctr0_init", c0, 40'h0);
    reset_i = 1'b0;
    tick(1);
    t_store_miss();
    t_disambig();
    t_dis_retrigger();
    t_walk();
    t_float();
    t_multiply();
    t_mid_reset();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    $display("mismatch watchdog expected finish seen hang");
    report_and_stop();
  end

endmodule : tb_top
